// File: bench/pto_far_side.sv
// Model of the outside world: the trigger source and the emergency stop source.
// Assumes the bench calls its tasks hierarchically from a process clocked by clk.
`timescale 1ns/1ps
module pto_far_side (
  // Clock.
  input wire logic clk,
  // Pins driven into the block.
  output logic triggerPin,
  output logic emergencyStopPin_n
);
  // Both lines idle at a defined level so nothing unknown reaches the synchronisers.
  initial begin
    triggerPin = 1'b0;
    emergencyStopPin_n = 1'b1;
  end

  // Levels change only right after a clock edge, so each level lasts whole cycles.
  task automatic set_trig(input logic v);
    @(posedge clk);
    triggerPin <= v;
  endtask : set_trig

  // A pulse of n whole cycles; the bench never asks for less than one.
  task automatic pulse_trig(input int n);
    set_trig(1'b1);
    repeat (n) @(posedge clk);
    triggerPin <= 1'b0;
  endtask : pulse_trig

  // Emergency low phase; callers keep n at four cycles or more.
  task automatic emg_low(input int n);
    @(posedge clk);
    emergencyStopPin_n <= 1'b0;
    repeat (n) @(posedge clk);
    emergencyStopPin_n <= 1'b1;
  endtask : emg_low
endmodule : pto_far_side

// File: bench/pto_pulse_unit_tb_top.sv
// Self-checking bench for the pulse unit: Avalon-MM register access plus pin stimulus.
// Assumes the package, the constants header and the far-side model are compiled first.
`timescale 1ns/1ps
`include "pto_defs.svh"
module pto_pulse_unit_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic fastMode = 1'b1;
  logic emgPortInput = 1'b1;
  logic triggerPin;
  logic emergencyStopPin_n;
  pto_pkg::pto_pins_s pins;
  pto_pkg::pto_irq_s irqs;
  int trgN = 0;
  int perN = 0;
  int emgN = 0;
  int miscompares = 0;
  int check_count = 0;
  int bp;
  int bt;
  int be;
  int hi;
  logic [31:0] q;
  logic [1:0] selTab [3] = '{2'h2, 2'h1, 2'h0};
  int rejTab [3] = '{4, 8, 16};
  int latTab [3] = '{12, 20, 32};

  pto_pulse_unit i_pto_pulse_unit (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .fastMode(fastMode),
    .triggerPin(triggerPin), .emergencyStopPin_n(emergencyStopPin_n), .emgPortInput(emgPortInput),
    .pins(pins), .irqs(irqs));
  pto_far_side i_pto_far_side (.clk(clk), .triggerPin(triggerPin), .emergencyStopPin_n(emergencyStopPin_n));

  // Clock at 20 MHz.
  initial begin
    forever #25 clk = ~clk;
  end

  // Event pulses last one cycle, so they are tallied here and compared as differences.
  always @(posedge clk) begin
    if (irqs.trgStart === 1'b1) trgN <= trgN + 1;
    if (irqs.period === 1'b1) perN <= perN + 1;
    if (irqs.emergency === 1'b1) emgN <= emgN + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bus transfer; the request stands until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; pin checks wait two edges so register writes have landed.
  initial begin
    address <= 4'h0;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, `PTO_PERIOD_ADDR, 32'h0); chk(q & 32'hffff, 32'hffff);
    bus(0, 4'h7, 32'h0); chk(q, 32'h0);
    bus(0, `PTO_CR2_ADDR, 32'h0); chk(q & 32'h4, 32'h0);
    bus(1, `PTO_PERIOD_ADDR, 32'h7);
    bus(1, `PTO_DEAD_ADDR, 32'h2);
    bus(1, `PTO_CR1_ADDR, 32'h1e);
    bus(1, `PTO_CR2_ADDR, 32'h3);
    wt(2); chk({28'h0, pins}, 32'h4);
    // Run requested while the trigger sits at its stop level: nothing may start.
    bp = perN; bt = trgN;
    bus(1, `PTO_CR3_ADDR, 32'h1); wt(20); chk(perN - bp + trgN - bt, 32'h0);
    i_pto_far_side.set_trig(1'b1); wt(8); chk(trgN - bt, 32'h1);
    hi = 0;
    repeat (32) begin
      @(posedge clk);
      hi += (pins.outA === 1'b1);
    end
    chk(hi > 0 && hi < 32, 32'h1);
    chk((perN - bp) >= 3 && (perN - bp) <= 6, 32'h1);
    bus(1, `PTO_CR3_ADDR, 32'h0); wt(2); chk({28'h0, pins}, 32'h4);
    bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h10, 32'h0);
    // Plain timer with both outputs off, started by command.
    bp = perN;
    bus(1, `PTO_CR2_ADDR, 32'h0);
    bus(1, `PTO_CR3_ADDR, 32'h1); wt(30); chk((perN - bp) >= 3 && (perN - bp) <= 6, 32'h1);
    chk({28'h0, pins} & 32'h3, 32'h3);
    // Each filter rate: a pulse at the noise limit is dropped, a steady level is taken.
    for (int i = 0; i < 3; i++) begin
      bus(1, `PTO_CR3_ADDR, 32'h0);
      i_pto_far_side.set_trig(1'b0);
      wt(40);
      bus(1, `PTO_CR1_ADDR, {27'h0, 1'b1, selTab[i], 2'h2});
      bus(1, `PTO_CR3_ADDR, 32'h1);
      bt = trgN;
      i_pto_far_side.pulse_trig(rejTab[i]); wt(30); chk(trgN - bt, 32'h0);
      i_pto_far_side.set_trig(1'b1); wt(latTab[i]); chk(trgN - bt, 32'h1);
    end
    // Emergency stop while counting, first with the shared pin not in input mode.
    bus(1, `PTO_CR3_ADDR, 32'h0);
    bus(1, `PTO_CR1_ADDR, 32'h1e);
    bus(1, `PTO_CR2_ADDR, 32'h7);
    bus(1, `PTO_CR3_ADDR, 32'h1);
    @(posedge clk) emgPortInput <= 1'b0;
    be = emgN;
    i_pto_far_side.emg_low(8); wt(6); chk(emgN - be, 32'h0);
    @(posedge clk) emgPortInput <= 1'b1;
    wt(4);
    bp = perN;
    fork
      i_pto_far_side.emg_low(12);
      begin
        wt(10); chk({28'h0, pins}, 32'h4);
      end
    join
    hi = 0;
    repeat (24) begin
      @(posedge clk);
      hi += (pins.outA === 1'b1);
    end
    chk(hi, 32'h0);
    chk(emgN - be, 32'h1);
    bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h18, 32'h18);
    chk((perN - bp) >= 3, 32'h1);
    // Release refused while running, then retried with the pin still low.
    bus(1, `PTO_CR2_ADDR, 32'h87);
    bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h8, 32'h8);
    bus(1, `PTO_CR3_ADDR, 32'h0);
    fork
      i_pto_far_side.emg_low(30);
      begin
        wt(12);
        be = emgN;
        bus(1, `PTO_CR2_ADDR, 32'h87);
        wt(8);
        bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h8, 32'h8);
        chk(emgN - be, 32'h1);
      end
    join
    wt(4);
    bus(1, `PTO_CR3_ADDR, 32'h1); wt(2);
    bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h10, 32'h0);
    bus(1, `PTO_CR3_ADDR, 32'h0);
    bus(1, `PTO_CR2_ADDR, 32'h87);
    bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h8, 32'h0);
    bus(1, `PTO_CR1_ADDR, 32'h1e);
    bus(1, `PTO_CR2_ADDR, 32'h7);
    bus(1, `PTO_CR3_ADDR, 32'h1); wt(2);
    bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h10, 32'h10);
    // Leaving the fast modes wipes the registers and counter back to reset; the emergency latch is not reset.
    @(posedge clk) fastMode <= 1'b0;
    wt(2);
    @(posedge clk) fastMode <= 1'b1;
    wt(2);
    bus(0, `PTO_CR2_ADDR, 32'h0); chk(q & 32'h4, 32'h0);
    bus(0, `PTO_CR3_ADDR, 32'h0); chk(q & 32'h10, 32'h0);
    final_report();
  end

  // The whole sequence needs under two thousand cycles; this bound cuts off a hang.
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule : pto_pulse_unit_tb_top

// File: common/pto_defs.svh
// Constants for the pulse output and emergency stop block.
// Assumes inclusion by bare name from the bench and the design files.
//
// Overview of operation
// (R01) Initial-level 0: output starts low, goes high at dead-time match.
// (R02) Initial-level 1: output starts high, goes low at dead-time match.
// (R03) Output enable cleared: no waveform on that pin, port function kept.
// (R04) Both outputs disabled: still counts, period interrupt on period match.
// (R05) Trigger filter samples at fc/4, fc/2 or fc, five equal samples; 11 bypasses.
// (R06) Select 00 rejects 16/fc or less, accepts 20/fc, latency 21 to 24/fc.
// (R07) Select 01 rejects 8/fc or less, accepts 10/fc, latency 13 to 14/fc.
// (R08) Select 10 rejects 4/fc or less, accepts 5/fc, latency 5/fc.
// (R09) Bypass reacts 4/fc after synchroniser; source keeps pulses over 1/fc.
// (R10) Trigger-start interrupt on start edge, even in emergency; not clear or capture.
// (R11) Period interrupt on command start and each period wrap, even in emergency.
// (R12) Run written while trigger at stop level: no start; later start edge starts.
// (R13) Emergency enabled and pin low: outputs to initial levels, interrupt, counter runs.
// (R14) Source holds emergency pin low at least 4/fc.
// (R15) Emergency enable resets to 0; pin sampled on fc, only in input mode.
// (R16) Emergency flag set on shutdown and reads 1 while shut down.
// (R17) Release bit clears shutdown only with run bit 0 and stop mode 00.
// (R18) Release while pin low and enabled re-enters shutdown with new interrupt.
// (R19) Emergency interrupt whenever stop input accepted with enable 1.
// (R20) No restart during shutdown; software releases then rewrites controls.
// (R21) Outputs back to initial levels within 10/fc of emergency pin low.
// (R22) Runs only in high-speed run and idle modes; other modes reset it (the emergency latch and filter keep their state).
// (R23) Stop mode 00 and run cleared: halt at once, outputs to initial levels.
// (R24) Trigger input passes a synchronising flip-flop before the filter.
`ifndef PTO_DEFS_SVH
`define PTO_DEFS_SVH
// Register word addresses, one per register in consecutive order.
`define PTO_CR1_ADDR 4'h0
`define PTO_CR2_ADDR 4'h1
`define PTO_CR3_ADDR 4'h2
`define PTO_PERIOD_ADDR 4'h3
`define PTO_DEAD_ADDR 4'h4
// Control register one fields.
`define PTO_CR1_INI_A 0
`define PTO_CR1_INI_B 1
`define PTO_CR1_FSEL_LO 2
`define PTO_CR1_EDGE 4
`define PTO_CR1_TRIGMODE 5
// Control register two fields.
`define PTO_CR2_OE_A 0
`define PTO_CR2_OE_B 1
`define PTO_CR2_EMERGENCY_INPUT_ENABLE 2
`define PTO_CR2_EMERGENCY_RELEASE 7
// Control register three fields.
`define PTO_CR3_RUN 0
`define PTO_CR3_STM_LO 1
`define PTO_CR3_EMERGENCY_FLAG 3
`define PTO_CR3_CNTBUSY 4
// Reset values.
`define PTO_PERIOD_RST 16'hffff
`define PTO_DEAD_RST 16'h0000
// Filter: five equal samples accept a level.
`define PTO_FILT_SAMPLES 3'h5
`define PTO_FILT_DIV4 2'h3
`define PTO_FILT_DIV2 2'h1
// Emergency low-count threshold in fc cycles; the pin is taken on the third low cycle.
`define PTO_EMG_MIN_LOW 3'h2
`endif

// File: common/pto_pkg.sv
// Types for the pulse output and emergency stop block.
// Assumes the constants header sits beside it.
package pto_pkg;
  typedef enum logic [1:0] {
    PTO_IDLE = 2'h0,
    PTO_WAIT = 2'h1,
    PTO_COUNT = 2'h2
  } pto_run_e;

  typedef struct packed {
    logic outA;
    logic outB;
    logic oeA;
    logic oeB;
  } pto_pins_s;

  typedef struct packed {
    logic trgStart;
    logic period;
    logic emergency;
  } pto_irq_s;
endpackage : pto_pkg

// File: design/pto_emergency.sv
// Emergency shutdown latch with release handshake.
// Assumes the pin is already synchronised to clk.
`timescale 1ns/1ps
`include "pto_defs.svh"
module pto_emergency (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic enable,
  input wire logic pinLow,
  input wire logic release_req,
  input wire logic runBit,
  input wire logic [1:0] stopMode,
  // Status.
  output logic shutdown,
  output logic irq
);
  typedef struct packed {
    logic [2:0] lowCnt;
    logic down;
    logic irq;
  } pto_emg_s;
  pto_emg_s st;
  pto_emg_s next_st;
  logic accept;
  logic relOk;

  // A short glitch is ignored; the low must last three cycles.
  assign accept = enable && pinLow && st.lowCnt >= `PTO_EMG_MIN_LOW; // (R14)
  assign relOk = release_req && !runBit && stopMode == 2'h0; // (R17)

  always_comb begin
    next_st = st;
    next_st.irq = 1'h0;
    next_st.lowCnt = (enable && pinLow) ? ((st.lowCnt == 3'h7) ? st.lowCnt : st.lowCnt + 3'h1) : 3'h0;
    if (relOk) begin
      next_st.down = 1'h0;
    end
    // Set beats release, so a pin still low re-enters at once.
    if (accept && (!st.down || relOk)) begin
      next_st.down = 1'h1; // (R16)
      next_st.irq = 1'h1; // (R18) (R19)
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign shutdown = st.down;
  assign irq = st.irq;

  // A held low pin shuts down within four cycles.
  emg_response_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && pinLow)[*4] |-> shutdown)
    else $error("Emergency not entered in time."); // (R21)
  release_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    shutdown && !accept && (runBit || stopMode != 2'h0) |=> shutdown)
    else $error("Shutdown released while running."); // (R17)
endmodule : pto_emergency

// File: design/pto_noise_filter.sv
// Trigger noise filter: five equal samples at a selectable rate.
// Assumes the input is already synchronised to clk.
`timescale 1ns/1ps
`include "pto_defs.svh"
module pto_noise_filter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic [1:0] sampleSel,
  input wire logic syncIn,
  // Filtered level.
  output logic filtered
);
  typedef struct packed {
    logic [1:0] div;
    logic [2:0] cnt;
    logic last;
    logic level;
  } pto_filt_s;
  pto_filt_s st;
  pto_filt_s next_st;
  logic tick;

  // Sample enable: a one-cycle pulse from the divider at fc/4, fc/2 or fc.
  always_comb begin
    case (sampleSel)
      2'h0: tick = (st.div == `PTO_FILT_DIV4); // (R06)
      2'h1: tick = (st.div[0] == 1'h1); // (R07)
      default: tick = 1'h1; // (R08)
    endcase
  end

  // Counts equal samples; a changed sample restarts the run.
  always_comb begin
    next_st = st;
    next_st.div = st.div + 2'h1;
    if (sampleSel == 2'h3) begin
      next_st.level = syncIn; // (R09)
      next_st.cnt = 3'h0;
    end else if (tick) begin
      next_st.last = syncIn;
      if (syncIn != st.last) begin
        next_st.cnt = 3'h1;
      end else if (st.cnt < `PTO_FILT_SAMPLES) begin
        next_st.cnt = st.cnt + 3'h1;
      end
      if (syncIn == st.last && st.cnt + 3'h1 >= `PTO_FILT_SAMPLES) begin
        next_st.level = syncIn; // (R05)
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtered = st.level;

  // Bypass follows the input one cycle later.
  bypass_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    sampleSel == 2'h3 && $stable(sampleSel) |-> filtered == $past(syncIn))
    else $error("Bypass level not followed."); // (R09)
endmodule : pto_noise_filter

// File: design/pto_pulse_unit.sv
// Pulse output unit with trigger filter and emergency output stop.
// Assumes an Avalon-MM master on clk and raw pins from outside the clock domain.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pto_defs.svh"
module pto_pulse_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // System mode: high while in a high-speed run or idle mode.
  input wire logic fastMode,
  // Pins.
  input wire logic triggerPin,
  input wire logic emergencyStopPin_n,
  input wire logic emgPortInput,
  output pto_pkg::pto_pins_s pins,
  // Events, one-cycle pulses.
  output pto_pkg::pto_irq_s irqs
);
  typedef struct packed {
    logic [5:0] cr1;
    logic [2:0] cr2;
    logic [2:0] cr3;
    logic [15:0] period;
    logic [15:0] dead;
    logic [15:0] count;
    pto_pkg::pto_run_e run;
    logic outA;
    logic outB;
    logic trgS1;
    logic trgSync;
    logic emgS1;
    logic emgSync;
    logic filtLast;
    logic ack;
    logic [31:0] rdata;
    pto_pkg::pto_irq_s irq;
  } pto_state_s;
  pto_state_s st;
  pto_state_s next_st;
  logic filtered;
  logic shutdown;
  logic emgIrq;
  logic emgRelease;
  logic edgeSel;
  logic startLevel;
  logic stopLevel;
  logic startEdge;
  logic wrStrobe;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Address decode used by read and write paths alike.
  function automatic logic [2:0] decodeAddr(input logic [3:0] addr);
    case (addr)
      `PTO_CR1_ADDR: decodeAddr = 3'h1;
      `PTO_CR2_ADDR: decodeAddr = 3'h2;
      `PTO_CR3_ADDR: decodeAddr = 3'h3;
      `PTO_PERIOD_ADDR: decodeAddr = 3'h4;
      `PTO_DEAD_ADDR: decodeAddr = 3'h5;
      default: decodeAddr = 3'h0;
    endcase
  endfunction : decodeAddr

  ////////////////////////////////////////////////////////////////////////
  // Submodules.

  pto_noise_filter uFilter (
    .clk(clk),
    .rst_n(rst_n),
    .sampleSel(st.cr1[`PTO_CR1_FSEL_LO +: 2]),
    .syncIn(st.trgS1),
    .filtered(filtered)
  );

  // Emergency input only counts while the shared pin is an input.
  pto_emergency uEmg (
    .clk(clk),
    .rst_n(rst_n),
    .enable(st.cr2[`PTO_CR2_EMERGENCY_INPUT_ENABLE] && emgPortInput),
    .pinLow(!st.emgSync),
    .release_req(emgRelease),
    .runBit(st.cr3[`PTO_CR3_RUN]),
    .stopMode(st.cr3[`PTO_CR3_STM_LO +: 2]),
    .shutdown(shutdown),
    .irq(emgIrq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Trigger levels and bus strobes.

  // The first sync stage feeds the filter, which is itself a second stage.
  assign edgeSel = st.cr1[`PTO_CR1_EDGE];
  assign startLevel = edgeSel ? filtered : !filtered;
  assign stopLevel = !startLevel;
  assign startEdge = startLevel && (edgeSel ? !st.filtLast : st.filtLast);
  assign wrStrobe = write && !st.ack;
  assign emgRelease = wrStrobe && decodeAddr(address) == 3'h2 && writedata[`PTO_CR2_EMERGENCY_RELEASE]; // (R17)

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    next_st = st;
    next_st.trgS1 = triggerPin; // (R24)
    next_st.trgSync = st.trgS1;
    next_st.emgS1 = emergencyStopPin_n; // (R15)
    next_st.emgSync = st.emgS1;
    next_st.filtLast = filtered;
    next_st.irq = '0;
    next_st.irq.emergency = emgIrq; // (R13)
    next_st.ack = (read || write) && !st.ack;

    // Register reads: unmapped addresses read as zero.
    case (decodeAddr(address))
      3'h1: next_st.rdata = {26'h0, st.cr1};
      3'h2: next_st.rdata = {29'h0, st.cr2};
      3'h3: next_st.rdata = {27'h0, (st.run == pto_pkg::PTO_COUNT), shutdown, st.cr3}; // (R16)
      3'h4: next_st.rdata = {16'h0, st.period};
      3'h5: next_st.rdata = {16'h0, st.dead};
      default: next_st.rdata = 32'h0;
    endcase

    // Register writes; release bit is write-only.
    if (wrStrobe) begin
      case (decodeAddr(address))
        3'h1: next_st.cr1 = writedata[5:0];
        3'h2: next_st.cr2 = writedata[2:0];
        3'h3: next_st.cr3 = writedata[2:0];
        3'h4: next_st.period = writedata[15:0];
        3'h5: next_st.dead = writedata[15:0];
        default: next_st.cr1 = st.cr1;
      endcase
    end

    // Counter sequencing.
    case (st.run)
      pto_pkg::PTO_IDLE: begin
        if (next_st.cr3[`PTO_CR3_RUN] && !st.cr3[`PTO_CR3_RUN] && !shutdown) begin // (R20)
          next_st.count = 16'h0;
          next_st.outA = st.cr1[`PTO_CR1_INI_A];
          next_st.outB = st.cr1[`PTO_CR1_INI_B];
          if (stopLevel) begin
            next_st.run = pto_pkg::PTO_WAIT; // (R12)
          end else begin
            next_st.run = pto_pkg::PTO_COUNT;
            next_st.irq.period = 1'h1; // (R11)
          end
        end
      end
      pto_pkg::PTO_WAIT: begin
        if (startEdge) begin
          next_st.run = pto_pkg::PTO_COUNT;
          next_st.irq.trgStart = 1'h1; // (R10)
        end
      end
      pto_pkg::PTO_COUNT: begin
        if (stopLevel) begin
          next_st.run = pto_pkg::PTO_WAIT;
          next_st.count = 16'h0;
          next_st.outA = st.cr1[`PTO_CR1_INI_A];
          next_st.outB = st.cr1[`PTO_CR1_INI_B];
        end else if (st.count >= st.period) begin
          next_st.count = 16'h0;
          next_st.irq.period = 1'h1; // (R04) (R11)
          next_st.outA = st.cr1[`PTO_CR1_INI_A];
          next_st.outB = st.cr1[`PTO_CR1_INI_B];
        end else begin
          next_st.count = st.count + 16'h1;
          if (st.count == st.dead) begin
            next_st.outA = !st.cr1[`PTO_CR1_INI_A]; // (R01) (R02)
            next_st.outB = !st.cr1[`PTO_CR1_INI_B];
          end
        end
      end
      default: next_st.run = pto_pkg::PTO_IDLE;
    endcase

    // Run cleared, whatever the stop mode: halt at once, outputs initial.
    if (!next_st.cr3[`PTO_CR3_RUN]) begin
      next_st.run = pto_pkg::PTO_IDLE; // (R23)
      next_st.count = 16'h0;
      next_st.outA = st.cr1[`PTO_CR1_INI_A];
      next_st.outB = st.cr1[`PTO_CR1_INI_B];
    end

    // Leaving the fast modes puts this block's registers back to reset; the filter and emergency latch keep theirs.
    if (!fastMode) begin
      next_st = '0; // (R22)
      next_st.period = `PTO_PERIOD_RST;
      next_st.dead = `PTO_DEAD_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0; // (R15)
      st.period <= `PTO_PERIOD_RST;
      st.dead <= `PTO_DEAD_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Emergency forces initial levels while the counter keeps going.
  assign pins.outA = shutdown ? st.cr1[`PTO_CR1_INI_A] : st.outA; // (R13)
  assign pins.outB = shutdown ? st.cr1[`PTO_CR1_INI_B] : st.outB;
  assign pins.oeA = !st.cr2[`PTO_CR2_OE_A]; // (R03)
  assign pins.oeB = !st.cr2[`PTO_CR2_OE_B];
  assign irqs = st.irq;
  assign readdata = st.rdata;
  assign waitrequest = (read || write) && !st.ack;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence cmdStartStop;
    st.run == pto_pkg::PTO_IDLE && next_st.run == pto_pkg::PTO_WAIT;
  endsequence

  no_period_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmdStartStop |=> !irqs.period)
    else $error("Period event on blocked start."); // (R12)
  halt_init_a: assert property (@(posedge clk) disable iff (!rst_n)
    fastMode && !next_st.cr3[`PTO_CR3_RUN] |=> st.run == pto_pkg::PTO_IDLE && st.count == 16'h0)
    else $error("Counter not halted."); // (R23)
  mode_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !fastMode |=> st.cr2 == 3'h0 && st.run == pto_pkg::PTO_IDLE)
    else $error("Slow mode did not reset."); // (R22)
  emg_outputs_a: assert property (@(posedge clk) disable iff (!rst_n)
    shutdown |-> pins.outA == st.cr1[`PTO_CR1_INI_A] && pins.outB == st.cr1[`PTO_CR1_INI_B])
    else $error("Outputs active in shutdown."); // (R13)
  wrap_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    fastMode && st.run == pto_pkg::PTO_COUNT && !stopLevel && st.count >= st.period
      && next_st.cr3[`PTO_CR3_RUN] |=> irqs.period && st.count == 16'h0)
    else $error("Missing period event."); // (R11)
  trig_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    fastMode && st.run == pto_pkg::PTO_WAIT && startEdge && next_st.cr3[`PTO_CR3_RUN] |=> irqs.trgStart)
    else $error("Missing trigger start event."); // (R10)
  no_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    shutdown && st.run == pto_pkg::PTO_IDLE |=> st.run == pto_pkg::PTO_IDLE)
    else $error("Restart during shutdown."); // (R20)
  oe_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    !st.cr2[`PTO_CR2_OE_A] |-> pins.oeA)
    else $error("Disabled output driven."); // (R03)
endmodule : pto_pulse_unit
